//--- dtr_consts.vh
// Constants for the SDRAM command timing and refresh engine
`ifndef DTR_CONSTS_VH
`define DTR_CONSTS_VH

// ----------------------------------------
// Command codes
// ----------------------------------------
`define DTR_CMD_NOP   3'h0
`define DTR_CMD_ACT   3'h1
`define DTR_CMD_PRE   3'h2
`define DTR_CMD_PALL  3'h3
`define DTR_CMD_RD    3'h4
`define DTR_CMD_WR    3'h5
`define DTR_CMD_REF   3'h6
`define DTR_CMD_SREF  3'h7

// ----------------------------------------
// Refresh stagger groups (chip select masks)
// ----------------------------------------
`define DTR_GRP0      4'h1
`define DTR_GRP1      4'h2
`define DTR_GRP2      4'hC
`define DTR_ALL_CS    4'hF
`define DTR_STG_LAST  2'h2

// ----------------------------------------
// Burst and launch figures
// ----------------------------------------
`define DTR_BLEN_4    4'h4
`define DTR_BLEN_8    4'h8
`define DTR_BCYC_4    3'h2
`define DTR_BCYC_8    3'h4
`define DTR_WL_BASE   2'h1
`define DTR_A10_BIT   10
`define DTR_FULL_BYTE 8'hFF

`endif

//--- dtr_bank_timer.v
// Per chip select open-row tracking and inter-command timers
`timescale 1ns/1ps
`default_nettype none

module dtr_bank_timer #(
	parameter CW = 5,
	parameter RW = 14,
	parameter PW = 10
) (
	input  wire          sys_clk,
	input  wire          reset,
	input  wire          tick,
	input  wire          act,
	input  wire          pchg,
	input  wire          acc,
	input  wire          wr_done,
	input  wire [RW-1:0] row_in,
	input  wire [CW-1:0] act_to_act_cycles,
	input  wire [CW-1:0] act_to_pchg_cycles,
	input  wire [CW-1:0] act_to_rdwr_cycles,
	input  wire [CW-1:0] pchg_to_act_cycles,
	input  wire [CW-1:0] write_recovery_cycles,
	input  wire [CW-1:0] write_to_read_cycles,
	input  wire [PW-1:0] page_hold_count,
	output reg           open_r,
	output reg  [RW-1:0] row_r,
	output wire          can_act,
	output wire          can_pchg,
	output wire          can_rdwr,
	output wire          can_rd,
	output wire          page_expired
);

	reg [CW-1:0] aa_r;
	reg [CW-1:0] ap_r;
	reg [CW-1:0] ar_r;
	reg [CW-1:0] pa_r;
	reg [CW-1:0] wrc_r;
	reg [CW-1:0] wtr_r;
	reg [PW-1:0] pg_r;

	localparam [CW-1:0] CW_ONE = {{(CW-1){1'b0}}, 1'b1};
	localparam [PW-1:0] PW_ONE = {{(PW-1){1'b0}}, 1'b1};

	// ----------------------------------------
	// Interval checks: an interval loaded with N allows the command N ticks later
	// ----------------------------------------
	assign can_act      = (aa_r <= 1) && (pa_r <= 1) && !open_r;
	assign can_pchg     = open_r && (ap_r <= 1) && (wrc_r <= 1);
	assign can_rdwr     = (ar_r <= 1);
	assign can_rd       = (wtr_r <= 1);
	assign page_expired = open_r && (pg_r == {PW{1'b0}});

	// ----------------------------------------
	// Counters in memory clock cycles
	// ----------------------------------------
	always @(posedge sys_clk)
	begin
		if (reset)
		begin
			open_r <= 1'b0;
			row_r  <= {RW{1'b0}};
			aa_r   <= {CW{1'b0}};
			ap_r   <= {CW{1'b0}};
			ar_r   <= {CW{1'b0}};
			pa_r   <= {CW{1'b0}};
			wrc_r  <= {CW{1'b0}};
			wtr_r  <= {CW{1'b0}};
			pg_r   <= {PW{1'b0}};
		end
		else if (tick)
		begin
			if (act)
			begin
				open_r <= 1'b1;
				row_r  <= row_in;
				aa_r   <= act_to_act_cycles;
				ap_r   <= act_to_pchg_cycles;
				ar_r   <= act_to_rdwr_cycles;
			end
			else
			begin
				if (aa_r != {CW{1'b0}})
					aa_r <= aa_r - CW_ONE;
				if (ap_r != {CW{1'b0}})
					ap_r <= ap_r - CW_ONE;
				if (ar_r != {CW{1'b0}})
					ar_r <= ar_r - CW_ONE;
			end
			if (pchg)
			begin
				open_r <= 1'b0;
				pa_r   <= pchg_to_act_cycles;
			end
			else if (pa_r != {CW{1'b0}})
				pa_r <= pa_r - CW_ONE;
			if (act || acc)
				pg_r <= page_hold_count;
			else if (pg_r != {PW{1'b0}})
				pg_r <= pg_r - PW_ONE;
		end
		if (!reset && wr_done)
		begin
			wrc_r <= write_recovery_cycles;
			wtr_r <= write_to_read_cycles;
		end
		else if (!reset && tick)
		begin
			if (wrc_r != {CW{1'b0}})
				wrc_r <= wrc_r - CW_ONE;
			if (wtr_r != {CW{1'b0}})
				wtr_r <= wtr_r - CW_ONE;
		end
	end

endmodule

`default_nettype wire

//--- dtr_engine.v
// SDRAM command timing and refresh engine
//
// How it works
// - Single-beat read runs whole burst, extras dropped
// - Short writes mask beats; ECC partial write does RMW
// - Short read always runs its full burst
// - Intervals whole cycles; column latency in halves
// - Activate-to-activate spacing per chip select
// - Activate-to-precharge spacing enforced
// - Activate-to-read/write spacing enforced
// - Page timer reloads on access, expiry precharges
// - Read data expected column plus additive latency
// - Precharge-to-activate/refresh spacing enforced
// - Refresh every interval; posted count sets rounds
// - Refresh recovery plus extension holds off activates
// - Write recovery before precharge after last beat
// - Write-to-read spacing after last write pair
// - Write launch delayed quarter steps after one cycle
// - Registered DIMM adds one write data cycle
// - Refresh waits for running transaction to finish
// - Refresh: finish, precharge open, then auto-refresh
// - Three fixed staggered groups, never shortened
// - Self-refresh entry: one command, all chip selects
// - Commands launched on memory clock rising edge
// - Burst four; eight only for first generation
// - All banks precharged before auto-refresh
// - Page hold zero closes page after access
`timescale 1ns/1ps
`include "dtr_consts.vh"
`default_nettype none

module dtr_engine #(
	parameter CW = 5,
	parameter RW = 14,
	parameter PW = 10,
	parameter IW = 16,
	parameter LW = 10
) (
	input  wire          sys_clk,
	input  wire          reset,
	input  wire          mem_clk,
	input  wire          mem_en,
	input  wire          ddr2_mode,
	input  wire          burst8_en,
	input  wire          ecc_en,
	input  wire          registered_dimm_en,
	input  wire          sleep_req,
	input  wire [CW-1:0] act_to_act_cycles,
	input  wire [CW-1:0] act_to_pchg_cycles,
	input  wire [CW-1:0] act_to_rdwr_cycles,
	input  wire [CW-1:0] pchg_to_act_cycles,
	input  wire [CW-1:0] write_recovery_cycles,
	input  wire [CW-1:0] write_to_read_cycles,
	input  wire [CW-1:0] refresh_recovery_cycles,
	input  wire [2:0]    refresh_recovery_extension,
	input  wire [PW-1:0] page_hold_count,
	input  wire [IW-1:0] refresh_interval_count,
	input  wire [2:0]    posted_refresh_count,
	input  wire [3:0]    column_latency_setting,
	input  wire [2:0]    additive_latency,
	input  wire [2:0]    write_data_delay,
	input  wire          req_valid,
	input  wire          req_write,
	input  wire [1:0]    req_cs,
	input  wire [2:0]    req_bank,
	input  wire [RW-1:0] req_row,
	input  wire [LW-1:0] req_col,
	input  wire [1:0]    req_beats,
	input  wire [7:0]    req_byte_en,
	output reg           req_ready_r,
	output reg  [2:0]    cmd_code_r,
	output reg  [3:0]    cmd_cs_r,
	output reg  [2:0]    cmd_bank_r,
	output reg  [RW-1:0] cmd_addr_r,
	output reg  [7:0]    rd_keep_mask_r,
	output reg           read_expect_r,
	output reg  [7:0]    write_byte_masks_r,
	output reg  [7:0]    wr_beat_mask_r,
	output reg           wr_launch_r,
	output reg           refresh_pending_r,
	output reg           self_refresh_r
);

	localparam [2:0] S_IDLE    = 3'h0;
	localparam [2:0] S_ACCESS  = 3'h1;
	localparam [2:0] S_BURST   = 3'h2;
	localparam [2:0] S_REF_PRE = 3'h3;
	localparam [2:0] S_REF_WT  = 3'h4;
	localparam [2:0] S_REF_AR  = 3'h5;
	localparam [2:0] S_REF_REC = 3'h6;
	localparam [2:0] S_SREF    = 3'h7;

	function [3:0] grp_mask;
		input [1:0] stg;
		begin
			case (stg)
				2'h0:    grp_mask = `DTR_GRP0;
				2'h1:    grp_mask = `DTR_GRP1;
				default: grp_mask = `DTR_GRP2;
			endcase
		end
	endfunction

	function [1:0] first_set;
		input [3:0] v;
		begin
			if (v[0])
				first_set = 2'h0;
			else if (v[1])
				first_set = 2'h1;
			else if (v[2])
				first_set = 2'h2;
			else
				first_set = 2'h3;
		end
	endfunction

	// ----------------------------------------
	// Memory clock sampling and period measurement
	// ----------------------------------------
	reg       mem_s1_r;
	reg       mem_s2_r;
	reg       mem_s3_r;
	reg [7:0] per_cnt_r;
	reg [7:0] per_r;
	wire      mem_rise = mem_s2_r & ~mem_s3_r;
	wire      mem_edge = mem_s2_r ^ mem_s3_r;

	always @(posedge sys_clk)
	begin
		if (reset)
		begin
			mem_s1_r  <= 1'b0;
			mem_s2_r  <= 1'b0;
			mem_s3_r  <= 1'b0;
			per_cnt_r <= 8'h00;
			per_r     <= 8'h00;
		end
		else
		begin
			mem_s1_r <= mem_clk;
			mem_s2_r <= mem_s1_r;
			mem_s3_r <= mem_s2_r;
			if (mem_rise)
			begin
				per_r     <= per_cnt_r + 8'h01;
				per_cnt_r <= 8'h00;
			end
			else if (per_cnt_r != 8'hFF)
				per_cnt_r <= per_cnt_r + 8'h01;
		end
	end

	// ----------------------------------------
	// Request holding registers and burst masks
	// ----------------------------------------
	reg [2:0]    state_r;
	reg [2:0]    state_nxt;
	reg          q_pend_r;
	reg          q_write_r;
	reg          rmw_rd_r;
	reg [1:0]    q_cs_r;
	reg [2:0]    q_bank_r;
	reg [RW-1:0] q_row_r;
	reg [LW-1:0] q_col_r;
	reg [1:0]    q_beats_r;
	reg [7:0]    q_bytes_r;
	wire         accept    = req_valid & req_ready_r;
	wire         long_bst  = burst8_en & ~ddr2_mode;
	wire [3:0]   blen      = long_bst ? `DTR_BLEN_8 : `DTR_BLEN_4;
	wire [2:0]   burst_cyc = long_bst ? `DTR_BCYC_8 : `DTR_BCYC_4;
	wire [7:0]   keep_w;

	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1)
		begin : gen_keep
			localparam [3:0] BI = g;
			assign keep_w[g] = ({2'b00, q_beats_r} >= BI) && (BI < blen);
		end
	endgenerate

	// ----------------------------------------
	// Per chip select timers
	// ----------------------------------------
	reg  [2:0]      cmd_nxt;
	reg  [3:0]      cs_nxt;
	reg  [RW-1:0]   addr_nxt;
	wire [3:0]      open_v;
	wire [3:0]      can_act_v;
	wire [3:0]      can_pchg_v;
	wire [3:0]      can_rdwr_v;
	wire [3:0]      can_rd_v;
	wire [3:0]      exp_v;
	wire [4*RW-1:0] row_v;
	reg  [1:0]      wcs_r;
	reg             brst_wr_r;
	wire            wr_done;

	generate
		for (g = 0; g < 4; g = g + 1)
		begin : gen_bank
			localparam [1:0] CI = g;
			dtr_bank_timer #(
				.CW (CW),
				.RW (RW),
				.PW (PW)
			) u_bank (
				.sys_clk               (sys_clk),
				.reset                 (reset),
				.tick                  (mem_rise),
				.act                   (cmd_nxt == `DTR_CMD_ACT && cs_nxt[g]),
				.pchg                  ((cmd_nxt == `DTR_CMD_PRE || cmd_nxt == `DTR_CMD_PALL)
				                        && cs_nxt[g]),
				.acc                   ((cmd_nxt == `DTR_CMD_RD || cmd_nxt == `DTR_CMD_WR)
				                        && cs_nxt[g]),
				.wr_done               (wr_done && wcs_r == CI),
				.row_in                (q_row_r),
				.act_to_act_cycles     (act_to_act_cycles),
				.act_to_pchg_cycles    (act_to_pchg_cycles),
				.act_to_rdwr_cycles    (act_to_rdwr_cycles),
				.pchg_to_act_cycles    (pchg_to_act_cycles),
				.write_recovery_cycles (write_recovery_cycles),
				.write_to_read_cycles  (write_to_read_cycles),
				.page_hold_count       (page_hold_count),
				.open_r                (open_v[g]),
				.row_r                 (row_v[g*RW +: RW]),
				.can_act               (can_act_v[g]),
				.can_pchg              (can_pchg_v[g]),
				.can_rdwr              (can_rdwr_v[g]),
				.can_rd                (can_rd_v[g]),
				.page_expired          (exp_v[g])
			);
		end
	endgenerate

	// ----------------------------------------
	// Refresh interval, recovery and read/write launch timing
	// ----------------------------------------
	reg  [IW-1:0] ref_cnt_r;
	reg  [CW:0]   rec_cnt_r;
	reg  [2:0]    rnd_r;
	reg  [1:0]    stg_r;
	reg           sref_mode_r;
	reg           ref_clr;
	reg           rec_load;
	reg  [4:0]    rd_cnt_r;
	reg           rd_wait_r;
	reg  [1:0]    wl_cnt_r;
	reg           wl_wait_r;
	reg  [8:0]    dly_cnt_r;
	reg           dly_wait_r;
	reg  [2:0]    brst_cnt_r;
	wire          rec_ok     = (rec_cnt_r <= 1);
	wire [CW:0]   rec_total  = {1'b0, refresh_recovery_cycles}
	                           + {{(CW-2){1'b0}}, refresh_recovery_extension};
	wire [4:0]    lat_half   = {1'b0, column_latency_setting}
	                           + {1'b0, additive_latency, 1'b0};
	wire [8:0]    dly_total  = {3'h0, per_r[7:2]} * {6'h00, write_data_delay};
	wire          burst_done = mem_rise && (brst_cnt_r == 3'h1);
	wire          ref_set    = mem_rise && (ref_cnt_r <= 1);
	assign wr_done = burst_done & brst_wr_r;

	// ----------------------------------------
	// Command selection, evaluated for the next rising edge
	// ----------------------------------------
	wire [RW-1:0] sel_row   = row_v[q_cs_r*RW +: RW];
	wire          sel_open  = open_v[q_cs_r];
	wire          rd_phase  = ~q_write_r | rmw_rd_r;
	wire [3:0]    exp_ready = exp_v & can_pchg_v;
	wire [3:0]    pre_mask  = grp_mask(stg_r) & open_v;

	always @*
	begin
		state_nxt = state_r;
		cmd_nxt   = `DTR_CMD_NOP;
		cs_nxt    = 4'h0;
		addr_nxt  = {RW{1'b0}};
		ref_clr   = 1'b0;
		rec_load  = 1'b0;
		case (state_r)
			S_IDLE:
			begin
				if (refresh_pending_r || sleep_req)
					state_nxt = S_REF_PRE;
				else if (q_pend_r && rec_ok)
					state_nxt = S_ACCESS;
				else if (exp_ready != 4'h0)
				begin
					cmd_nxt = `DTR_CMD_PRE;
					cs_nxt  = 4'h1 << first_set(exp_ready);
				end
			end
			S_ACCESS:
			begin
				if (sel_open && sel_row == q_row_r)
				begin
					if (can_rdwr_v[q_cs_r] && (!rd_phase || can_rd_v[q_cs_r]))
					begin
						cmd_nxt   = rd_phase ? `DTR_CMD_RD : `DTR_CMD_WR;
						cs_nxt    = 4'h1 << q_cs_r;
						addr_nxt  = {{(RW-LW){1'b0}}, q_col_r};
						state_nxt = S_BURST;
					end
				end
				else if (sel_open)
				begin
					if (can_pchg_v[q_cs_r])
					begin
						cmd_nxt = `DTR_CMD_PRE;
						cs_nxt  = 4'h1 << q_cs_r;
					end
				end
				else if (can_act_v[q_cs_r] && rec_ok)
				begin
					cmd_nxt  = `DTR_CMD_ACT;
					cs_nxt   = 4'h1 << q_cs_r;
					addr_nxt = q_row_r;
				end
			end
			S_BURST:
			begin
				if (burst_done)
					state_nxt = rmw_rd_r ? S_ACCESS : S_IDLE;
			end
			S_REF_PRE:
			begin
				if (stg_r != 2'h0 || (&(can_pchg_v | ~open_v)))
				begin
					if (pre_mask != 4'h0)
					begin
						cmd_nxt = `DTR_CMD_PALL;
						cs_nxt  = pre_mask;
						addr_nxt[`DTR_A10_BIT] = 1'b1;
					end
					if (stg_r == `DTR_STG_LAST)
						state_nxt = S_REF_WT;
				end
			end
			S_REF_WT:
			begin
				if (&can_act_v)
				begin
					if (sref_mode_r)
					begin
						cmd_nxt   = `DTR_CMD_SREF;
						cs_nxt    = `DTR_ALL_CS;
						state_nxt = S_SREF;
					end
					else
						state_nxt = S_REF_AR;
				end
			end
			S_REF_AR:
			begin
				cmd_nxt = `DTR_CMD_REF;
				cs_nxt  = grp_mask(stg_r);
				ref_clr = 1'b1;
				if (stg_r == `DTR_STG_LAST)
				begin
					rec_load  = 1'b1;
					state_nxt = S_REF_REC;
				end
			end
			S_REF_REC:
			begin
				if (rec_ok)
					state_nxt = (rnd_r != 3'h0) ? S_REF_AR : S_IDLE;
			end
			S_SREF:
			begin
				if (!sleep_req)
				begin
					rec_load  = 1'b1;
					state_nxt = S_REF_REC;
				end
			end
			default:
				state_nxt = S_IDLE;
		endcase
	end

	// ----------------------------------------
	// State, command outputs and request handling
	// ----------------------------------------
	always @(posedge sys_clk)
	begin
		if (reset)
		begin
			state_r           <= S_IDLE;
			cmd_code_r        <= `DTR_CMD_NOP;
			cmd_cs_r          <= 4'h0;
			cmd_bank_r        <= 3'h0;
			cmd_addr_r        <= {RW{1'b0}};
			req_ready_r       <= 1'b0;
			q_pend_r          <= 1'b0;
			q_write_r         <= 1'b0;
			rmw_rd_r          <= 1'b0;
			q_cs_r            <= 2'h0;
			q_bank_r          <= 3'h0;
			q_row_r           <= {RW{1'b0}};
			q_col_r           <= {LW{1'b0}};
			q_beats_r         <= 2'h0;
			q_bytes_r         <= `DTR_FULL_BYTE;
			stg_r             <= 2'h0;
			rnd_r             <= 3'h0;
			sref_mode_r       <= 1'b0;
			self_refresh_r    <= 1'b0;
			rd_keep_mask_r    <= 8'h00;
			write_byte_masks_r <= 8'h00;
			wr_beat_mask_r    <= 8'h00;
			wcs_r             <= 2'h0;
		end
		else
		begin
			req_ready_r <= mem_en & ~q_pend_r & ~accept;
			if (accept)
			begin
				q_pend_r  <= 1'b1;
				q_write_r <= req_write;
				rmw_rd_r  <= req_write & ecc_en & (req_byte_en != `DTR_FULL_BYTE);
				q_cs_r    <= req_cs;
				q_bank_r  <= req_bank;
				q_row_r   <= req_row;
				q_col_r   <= req_col;
				q_beats_r <= req_beats;
				q_bytes_r <= req_byte_en;
			end
			if (mem_rise)
			begin
				state_r        <= state_nxt;
				cmd_code_r     <= cmd_nxt;
				cmd_cs_r       <= cs_nxt;
				cmd_bank_r     <= q_bank_r;
				cmd_addr_r     <= addr_nxt;
				self_refresh_r <= (state_nxt == S_SREF);
				if (state_r == S_BURST && burst_done)
				begin
					if (rmw_rd_r)
						rmw_rd_r <= 1'b0;
					else
						q_pend_r <= 1'b0;
				end
				if (cmd_nxt == `DTR_CMD_RD)
					rd_keep_mask_r <= keep_w;
				if (cmd_nxt == `DTR_CMD_WR)
				begin
					wcs_r          <= q_cs_r;
					wr_beat_mask_r <= ~keep_w;
					write_byte_masks_r <= (!ecc_en && q_beats_r == 2'h0) ? ~q_bytes_r : 8'h00;
				end
				if (state_r == S_IDLE && state_nxt == S_REF_PRE)
				begin
					sref_mode_r <= ~refresh_pending_r;
					rnd_r       <= posted_refresh_count;
				end
				if (state_r == S_REF_REC && state_nxt == S_REF_AR)
					rnd_r <= rnd_r - 3'h1;
				if (state_r == S_SREF && state_nxt == S_REF_REC)
					rnd_r <= 3'h0;
				if ((state_r == S_REF_PRE && (state_nxt != state_r || stg_r != 2'h0
				     || (&(can_pchg_v | ~open_v)))) || state_r == S_REF_AR)
					stg_r <= (stg_r == `DTR_STG_LAST) ? 2'h0 : stg_r + 2'h1;
			end
		end
	end

	// ----------------------------------------
	// Refresh request, recovery, read latency and write launch counters
	// ----------------------------------------
	always @(posedge sys_clk)
	begin
		if (reset)
		begin
			ref_cnt_r         <= {IW{1'b0}};
			refresh_pending_r <= 1'b0;
			rec_cnt_r         <= {(CW+1){1'b0}};
			rd_cnt_r          <= 5'h00;
			rd_wait_r         <= 1'b0;
			read_expect_r     <= 1'b0;
			wl_cnt_r          <= 2'h0;
			wl_wait_r         <= 1'b0;
			dly_cnt_r         <= 9'h000;
			dly_wait_r        <= 1'b0;
			wr_launch_r       <= 1'b0;
			brst_cnt_r        <= 3'h0;
			brst_wr_r         <= 1'b0;
		end
		else
		begin
			if (mem_rise)
				ref_cnt_r <= (ref_cnt_r <= 1) ? refresh_interval_count
				                              : ref_cnt_r - {{(IW-1){1'b0}}, 1'b1};
			refresh_pending_r <= ref_set | (refresh_pending_r & ~(mem_rise & ref_clr));
			if (mem_rise && rec_load)
				rec_cnt_r <= rec_total;
			else if (mem_rise && rec_cnt_r != {(CW+1){1'b0}})
				rec_cnt_r <= rec_cnt_r - {{CW{1'b0}}, 1'b1};
			read_expect_r <= 1'b0;
			if (mem_rise && cmd_nxt == `DTR_CMD_RD)
			begin
				rd_cnt_r  <= lat_half;
				rd_wait_r <= 1'b1;
			end
			else if (rd_wait_r && mem_edge)
			begin
				rd_cnt_r <= rd_cnt_r - 5'h01;
				if (rd_cnt_r <= 5'h01)
				begin
					rd_wait_r     <= 1'b0;
					read_expect_r <= 1'b1;
				end
			end
			if (mem_rise && cmd_nxt == `DTR_CMD_WR)
			begin
				wl_cnt_r  <= registered_dimm_en ? `DTR_WL_BASE + 2'h1 : `DTR_WL_BASE;
				wl_wait_r <= 1'b1;
			end
			else if (wl_wait_r && mem_rise)
			begin
				wl_cnt_r <= wl_cnt_r - 2'h1;
				if (wl_cnt_r == 2'h1)
				begin
					wl_wait_r  <= 1'b0;
					dly_wait_r <= 1'b1;
					dly_cnt_r  <= dly_total;
				end
			end
			wr_launch_r <= 1'b0;
			if (dly_wait_r)
			begin
				if (dly_cnt_r == 9'h000)
				begin
					dly_wait_r  <= 1'b0;
					wr_launch_r <= 1'b1;
				end
				else
					dly_cnt_r <= dly_cnt_r - 9'h001;
			end
			if (read_expect_r && !brst_wr_r)
				brst_cnt_r <= burst_cyc;
			else if (wr_launch_r)
				brst_cnt_r <= burst_cyc;
			else if (mem_rise && brst_cnt_r != 3'h0)
				brst_cnt_r <= brst_cnt_r - 3'h1;
			if (mem_rise && cmd_nxt == `DTR_CMD_WR)
				brst_wr_r <= 1'b1;
			else if (mem_rise && cmd_nxt == `DTR_CMD_RD)
				brst_wr_r <= 1'b0;
		end
	end

endmodule

`default_nettype wire

//--- dtr_engine_checker.sv
// Assertion checker for the timing and refresh engine
`timescale 1ns/1ps
`include "dtr_consts.vh"
`default_nettype none
module dtr_engine_checker #(parameter RW = 14) (
	input wire logic          sys_clk,
	input wire logic          reset,
	input wire logic          sleep_req,
	input wire logic          req_valid,
	input wire logic          req_ready_r,
	input wire logic [2:0]    cmd_code_r,
	input wire logic [3:0]    cmd_cs_r,
	input wire logic [RW-1:0] cmd_addr_r,
	input wire logic          read_expect_r,
	input wire logic          wr_launch_r,
	input wire logic          self_refresh_r
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	sequence s_ref(logic [3:0] g);
		##[18:22] cmd_code_r == `DTR_CMD_REF && cmd_cs_r == g;
	endsequence
	AST_REF_STAGGER: assert property ($changed(cmd_code_r) && cmd_code_r == `DTR_CMD_REF
		|-> cmd_cs_r == `DTR_GRP0 ##0 s_ref(`DTR_GRP1) ##0 s_ref(`DTR_GRP2)) else $error("stagger");
	AST_PALL_A10: assert property (cmd_code_r == `DTR_CMD_PALL |-> cmd_addr_r[`DTR_A10_BIT])
		else $error("pall a10");
	AST_SREF_CS: assert property (cmd_code_r == `DTR_CMD_SREF |-> cmd_cs_r == `DTR_ALL_CS)
		else $error("sref cs");
	AST_SREF_SLEEP: assert property ($rose(self_refresh_r) |-> sleep_req)
		else $error("sref entry");
	AST_RDY_TAKE: assert property (req_valid && req_ready_r |=> !req_ready_r [*8])
		else $error("ready");
	AST_RDX_PULSE: assert property (read_expect_r |=> !read_expect_r)
		else $error("read expect");
	AST_WL_PULSE: assert property (wr_launch_r |=> !wr_launch_r)
		else $error("write launch");
	AST_CMD_HOLD: assert property ($changed(cmd_code_r) |=> $stable(cmd_code_r) [*8])
		else $error("cmd hold");
endmodule
bind dtr_engine dtr_engine_checker #(.RW(RW)) u_dtr_engine_checker (.sys_clk, .reset,
	.sleep_req, .req_valid, .req_ready_r, .cmd_code_r, .cmd_cs_r, .cmd_addr_r,
	.read_expect_r, .wr_launch_r, .self_refresh_r);
`default_nettype wire

//--- dtr_mem_model.sv
// Memory-side model: free-running memory clock and command tracker
`timescale 1ns/1ps
`include "dtr_consts.vh"
`default_nettype none
module dtr_mem_model (
	input  wire logic [2:0] cmd_code_r,
	input  wire logic [3:0] cmd_cs_r,
	output var logic        mem_clk,
	output var logic  [7:0] ref_cnt,
	output var logic  [7:0] rd_cnt,
	output var logic  [7:0] bad_cnt
);
	logic [3:0] open_r;
	initial
	begin
		mem_clk = 1'b0;
		ref_cnt = 8'h00;
		rd_cnt = 8'h00;
		bad_cnt = 8'h00;
		open_r = 4'h0;
		#3;
		forever #80 mem_clk = ~mem_clk;
	end
	always @(negedge mem_clk)
	begin
		if (cmd_code_r == `DTR_CMD_ACT)
			open_r <= open_r | cmd_cs_r;
		else if (cmd_code_r == `DTR_CMD_PRE || cmd_code_r == `DTR_CMD_PALL)
			open_r <= open_r & ~cmd_cs_r;
		rd_cnt <= rd_cnt + {7'h00, cmd_code_r == `DTR_CMD_RD};
		ref_cnt <= ref_cnt + {7'h00, cmd_code_r == `DTR_CMD_REF};
		bad_cnt <= bad_cnt + {7'h00, (cmd_code_r[2:1] == 2'b11 && |(open_r & cmd_cs_r))
			|| (cmd_code_r[2:1] == 2'b10 && (open_r & cmd_cs_r) != cmd_cs_r)};
	end
endmodule
`default_nettype wire

//--- dtr_engine_tb.sv
// Self-checking bench for the timing and refresh engine
`timescale 1ns/1ps
`include "dtr_consts.vh"
`default_nettype none
module dtr_engine_tb;
	logic        sys_clk = 1'b0, reset = 1'b1, mem_en = 1'b0, ddr2_mode = 1'b0;
	logic        burst8_en = 1'b0, ecc_en = 1'b0, registered_dimm_en = 1'b0, sleep_req = 1'b0;
	logic        req_valid = 1'b0, req_write = 1'b0;
	logic [4:0]  tv = 5'h02;
	logic [2:0]  refresh_recovery_extension = 3'h0, posted_refresh_count = 3'h0, req_bank = 3'h1;
	logic [2:0]  additive_latency = 3'h0, write_data_delay = 3'h0;
	logic [9:0]  page_hold_count = 10'h014, req_col = 10'h000;
	logic [15:0] refresh_interval_count = 16'h0028;
	logic [3:0]  column_latency_setting = 4'h4;
	logic [1:0]  req_cs = 2'h0, req_beats = 2'h0;
	logic [13:0] req_row = 14'h0010;
	logic [7:0]  req_byte_en = 8'hFF, km, wm, bm, n;
	wire  [4:0]  act_to_act_cycles = tv, act_to_pchg_cycles = tv, act_to_rdwr_cycles = tv;
	wire  [4:0]  pchg_to_act_cycles = tv, write_recovery_cycles = tv, write_to_read_cycles = tv;
	wire  [4:0]  refresh_recovery_cycles = tv;
	wire         mem_clk, req_ready_r, read_expect_r, wr_launch_r, refresh_pending_r, self_refresh_r;
	wire  [2:0]  cmd_code_r, cmd_bank_r;
	wire  [3:0]  cmd_cs_r;
	wire  [13:0] cmd_addr_r;
	wire  [7:0]  rd_keep_mask_r, write_byte_masks_r, wr_beat_mask_r, ref_cnt, rd_cnt, bad_cnt;
	int          num_errors = 0, tests_run = 0, i, p;
	dtr_engine u_dtr_engine (.*);
	dtr_mem_model u_dtr_mem_model (.*);
	always #4 sys_clk = ~sys_clk;
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic test_done;
		if (num_errors == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic acc(input logic w, input logic [1:0] b, input logic [7:0] be);
		int k;
		@(posedge sys_clk);
		req_valid <= 1'b1;
		req_write <= w;
		req_beats <= b;
		req_byte_en <= be;
		req_row <= req_row + {13'h0000, w};
		@(negedge sys_clk);
		for (k = 0; k < 9000 && req_ready_r !== 1'b1; k++) @(negedge sys_clk);
		@(posedge sys_clk);
		req_valid <= 1'b0;
		@(negedge sys_clk);
		for (k = 0; k < 9000 && cmd_code_r !== {2'b10, w}; k++) @(negedge sys_clk);
		chk(cmd_code_r, {2'b10, w});
		chk(cmd_bank_r, req_bank);
		chk(cmd_addr_r[7:0], req_col[7:0]);
		km = rd_keep_mask_r;
		wm = wr_beat_mask_r;
		bm = write_byte_masks_r;
		for (k = 0; k < 400 && (w ? wr_launch_r : read_expect_r) !== 1'b1; k++) @(negedge sys_clk);
		chk(k < 400, 1'b1);
		if (!w)
			chk(k[7:0], 8'h0A * {3'h0, column_latency_setting
				+ {additive_latency, 1'b0}});
		for (k = 0; k < 9000 && req_ready_r !== 1'b1; k++) @(negedge sys_clk);
		chk(req_ready_r, 1'b1);
		@(posedge sys_clk);
	endtask
	initial
	begin
		repeat (4) @(posedge sys_clk);
		reset <= 1'b0;
		mem_en <= 1'b1;
		for (i = 0; i < 100 && refresh_pending_r !== 1'b1; i++) @(negedge sys_clk);
		chk(refresh_pending_r, 1'b1);
		for (p = 0; p < 3; p++)
		begin
			acc(1'b0, 2'h0, 8'hFF);
			chk(km, 8'h01);
			acc(1'b0, 2'h1, 8'hFF);
			chk(km, 8'h03);
			acc(1'b1, 2'h0, 8'h0F);
			chk(bm, 8'hF0);
			chk(wm[3:0], 4'hE);
			if (p == 1)
				chk(wm[7:4], 4'hF);
			acc(1'b1, 2'h3, 8'hFF);
			chk(wm[3:0], 4'h0);
			n = rd_cnt;
			ecc_en <= 1'b1;
			acc(1'b1, 2'h0, 8'h0F);
			chk(rd_cnt - n, 8'h01);
			chk(bm, 8'h00);
			ecc_en <= 1'b0;
			burst8_en <= 1'b1;
			registered_dimm_en <= 1'b1;
			ddr2_mode <= p[0];
			write_data_delay <= 3'h2;
			additive_latency <= 3'h1;
			column_latency_setting <= 4'h5;
			tv <= 5'h03;
			page_hold_count <= 10'h000;
			posted_refresh_count <= 3'h1;
			refresh_recovery_extension <= 3'h2;
			req_cs <= req_cs + 2'h1;
			req_bank <= req_bank + 3'h1;
			req_col <= req_col + 10'h005;
		end
		chk(ref_cnt != 8'h00, 1'b1);
		chk(bad_cnt, 8'h00);
		sleep_req <= 1'b1;
		for (i = 0; i < 9000 && self_refresh_r !== 1'b1; i++) @(negedge sys_clk);
		chk(self_refresh_r, 1'b1);
		@(posedge sys_clk);
		sleep_req <= 1'b0;
		acc(1'b0, 2'h0, 8'hFF);
		chk(km, 8'h01);
		test_done;
	end
	initial
	begin
		repeat (60000) @(posedge sys_clk);
		num_errors++;
		test_done;
	end
endmodule
`default_nettype wire
